// file: core/dpram_pkg.sv
// Shared constants for the synchronous dual-port memory port and controller
package dpram_pkg;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 16;
   localparam int LANE_W = 8;
   localparam logic [15:0] COUNTER_CLEAR_ADDR = 16'h0000;
   // Cross-port timing at the 50 MHz system clock
   localparam int CLK_PERIOD_NS = 20;
   localparam int WRITE_TO_READ_DELAY_NS = 30;
   localparam int PORT_CLOCK_SKEW_NS = 9;
   localparam int FLOW_ACCESS_TIME_NS = 15;
   // Reader wait after a cross-port write, rounded up to whole cycles
   localparam int WRITE_TO_READ_CYCLES =
      (WRITE_TO_READ_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SKEW_READ_CYCLES =
      (PORT_CLOCK_SKEW_NS + FLOW_ACCESS_TIME_NS + CLK_PERIOD_NS - 1)
      / CLK_PERIOD_NS;
   // Controller wishbone register offsets (byte addresses)
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_ADDR = 8'h04;
   localparam logic [7:0] REG_WDATA = 8'h08;
   localparam logic [7:0] REG_RDATA = 8'h0C;
   localparam logic [7:0] REG_STATUS = 8'h10;
   // Control register fields
   localparam int CTRL_GO = 0;
   localparam int CTRL_WRITE = 1;
   localparam int CTRL_UPPER = 2;
   localparam int CTRL_LOWER = 3;
   localparam int CTRL_MODE = 4;
   localparam int CTRL_INCR = 5;
   localparam int CTRL_CLEAR = 6;
   localparam int CTRL_BANK = 7;
   localparam int CTRL_NOP = 8;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   // Status fields
   localparam int STAT_BUSY = 0;
   localparam int STAT_DONE = 1;
   localparam int STAT_REWRITE = 2;
endpackage

// file: core/dpram_if.sv
// Pin-level link between a memory port and its controller
`timescale 1ns/100ps
interface dpram_if;
   logic select_low_active_n;
   logic select_high_active;
   logic write_n;
   logic address_strobe_load_n;
   logic count_advance_enable_n;
   logic counter_clear_n;
   logic upper_byte_select_n;
   logic lower_byte_select_n;
   logic output_enable_n;
   logic [dpram_pkg::ADDR_W-1:0] addr;
   logic [dpram_pkg::DATA_W-1:0] ctl_data;
   logic ctl_data_oe;
   logic [dpram_pkg::DATA_W-1:0] mem_data;
   logic mem_data_oe;
   wire [dpram_pkg::DATA_W-1:0] data_bus;
   assign data_bus = ctl_data_oe ? ctl_data :
      (mem_data_oe ? mem_data : '0);
   modport device (
      input select_low_active_n, select_high_active, write_n,
      input address_strobe_load_n, count_advance_enable_n, counter_clear_n,
      input upper_byte_select_n, lower_byte_select_n, output_enable_n,
      input addr, data_bus,
      output mem_data, mem_data_oe
   );
   modport ctrl (
      output select_low_active_n, select_high_active, write_n,
      output address_strobe_load_n, count_advance_enable_n, counter_clear_n,
      output upper_byte_select_n, lower_byte_select_n, output_enable_n,
      output addr, ctl_data, ctl_data_oe,
      input data_bus
   );
endinterface

// file: core/burst_counter.sv
// Burst address counter of one memory port
`timescale 1ns/100ps
module burst_counter #(
   parameter int ADDR_W = dpram_pkg::ADDR_W
) (
   input wire logic clk_i,
   input wire logic ce_i,
   input wire logic address_strobe_load_n_i,
   input wire logic count_advance_enable_n_i,
   input wire logic counter_clear_n_i,
   input wire logic [ADDR_W-1:0] addr_i,
   output logic [ADDR_W-1:0] count_o,
   output logic [ADDR_W-1:0] internal_addr_o
);
   logic [ADDR_W-1:0] count_r;
   logic [ADDR_W-1:0] count_nxt;

   always_comb begin
      count_nxt = count_r;
      if (!counter_clear_n_i) begin
         count_nxt = ADDR_W'(dpram_pkg::COUNTER_CLEAR_ADDR);
      end else if (!address_strobe_load_n_i) begin
         count_nxt = addr_i;
      end else if (!count_advance_enable_n_i) begin
         count_nxt = count_r + 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (ce_i) begin
         count_r <= count_nxt;
      end
   end

   // Clear wins the cycle, so the access goes to address zero at once
   always_comb begin
      if (!counter_clear_n_i) begin
         internal_addr_o = ADDR_W'(dpram_pkg::COUNTER_CLEAR_ADDR);
      end else if (!address_strobe_load_n_i) begin
         internal_addr_o = addr_i;
      end else begin
         internal_addr_o = count_r;
      end
   end

   assign count_o = count_r;
endmodule

// file: core/dpram_port.sv
// One port of the synchronous dual-port memory, clocked by the clk_i shared with the other port
// Functional notes
// - Sync inputs; output enable acts immediately
// - Deselect floats outputs after next edge (flow mode; pipelined after two edges)
// - Strobe low loads address every edge
// - Internal address: pins or counter
// - Counter clear never inserts idle cycle
// - Pipelined output state from previous controls
// - Controller flags a rewrite after no-operation
// - Reader waits write-to-read delay across ports
// - Large skew: wait skew plus access (the controller waits only the write-to-read delay)
// - Cross-port behaviour symmetric between ports
// - Depth expansion selects bank by chip-selects
// - Counter: clear, load, increment, hold
// - Pipelined data one cycle later
// - Selected only with both selects active
// - No simultaneous same-location writes
`timescale 1ns/100ps
module dpram_port #(
   parameter int ADDR_W = dpram_pkg::ADDR_W,
   parameter int DATA_W = dpram_pkg::DATA_W,
   parameter int DEPTH = 1 << dpram_pkg::ADDR_W
) (
   input wire logic clk_i,
   input wire logic other_clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic pipelined_i,
   dpram_if.device link,
   input wire logic other_we_i,
   input wire logic [ADDR_W-1:0] other_addr_i,
   input wire logic [DATA_W-1:0] other_wdata_i,
   input wire logic [1:0] other_lanes_i,
   output logic we_o,
   output logic [ADDR_W-1:0] addr_o,
   output logic [DATA_W-1:0] wdata_o,
   output logic [1:0] lanes_o
);
   localparam int LW = dpram_pkg::LANE_W;
   // Storage copy: own writes and the mirrored writes of the other port.
   // Both ports run on clk_i (one clock), so other_clk_i must equal clk_i.
   logic [DATA_W-1:0] mem_a [DEPTH];
   logic [ADDR_W-1:0] iaddr;
   logic selected;
   logic wr;
   logic rd;
   logic [DATA_W-1:0] flow_r;
   logic [DATA_W-1:0] flow_nxt;
   logic [DATA_W-1:0] pipe_r;
   logic [DATA_W-1:0] pipe_nxt;
   logic drive_flow_r;
   logic drive_flow_nxt;
   logic drive_pipe_r;
   logic drive_pipe_nxt;

   function automatic logic [DATA_W-1:0] merge(
      input logic [DATA_W-1:0] old_w,
      input logic [DATA_W-1:0] new_w,
      input logic [1:0] lanes);
      logic [DATA_W-1:0] m;
      m = old_w;
      if (lanes[0]) begin
         m[LW-1:0] = new_w[LW-1:0];
      end
      if (lanes[1]) begin
         m[DATA_W-1:LW] = new_w[DATA_W-1:LW];
      end
      return m;
   endfunction

   burst_counter #(.ADDR_W(ADDR_W)) u_counter (
      .clk_i(clk_i),
      .ce_i(ce_i),
      .address_strobe_load_n_i(link.address_strobe_load_n),
      .count_advance_enable_n_i(link.count_advance_enable_n),
      .counter_clear_n_i(link.counter_clear_n),
      .addr_i(link.addr),
      .count_o(),
      .internal_addr_o(iaddr)
   );

   assign selected = !link.select_low_active_n &&
      link.select_high_active;
   assign wr = selected && !link.write_n;
   assign rd = selected && link.write_n;

   // Write side exported so the other port can mirror it
   assign we_o = wr && ce_i;
   assign addr_o = iaddr;
   assign wdata_o = link.data_bus;
   assign lanes_o = {!link.upper_byte_select_n, !link.lower_byte_select_n};

   // Same location from both ports in one edge is undefined
   always_ff @(posedge clk_i) begin
      if (we_o) begin
         mem_a[iaddr] <= merge(mem_a[iaddr], link.data_bus, lanes_o);
      end
      if (other_we_i) begin
         mem_a[other_addr_i] <= merge(mem_a[other_addr_i], other_wdata_i,
            other_lanes_i);
      end
   end

   always_comb begin
      flow_nxt = flow_r;
      drive_flow_nxt = rd;
      if (rd) begin
         flow_nxt = mem_a[iaddr];
      end
      pipe_nxt = flow_r;
      drive_pipe_nxt = drive_flow_r;
      if (rst_i) begin
         drive_flow_nxt = 1'b0;
         drive_pipe_nxt = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (ce_i || rst_i) begin
         flow_r <= flow_nxt;
         pipe_r <= pipe_nxt;
         drive_flow_r <= drive_flow_nxt;
         drive_pipe_r <= drive_pipe_nxt;
      end
   end

   assign link.mem_data = pipelined_i ? pipe_r : flow_r;
   assign link.mem_data_oe = !link.output_enable_n &&
      (pipelined_i ? drive_pipe_r : drive_flow_r);
endmodule

// file: core/dpram_ctrl.sv
// Wishbone-driven controller for one memory port
//
// Implementation choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/100ps
module dpram_ctrl #(
   parameter int ADDR_W = dpram_pkg::ADDR_W,
   parameter int DATA_W = dpram_pkg::DATA_W
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   dpram_if.ctrl link
);
   typedef enum {IDLE, ISSUE, WAIT, CAPTURE} state_e;
   state_e state_r, state_nxt;
   logic [31:0] ctrl_r, ctrl_nxt;
   logic [ADDR_W-1:0] addr_r, addr_nxt;
   logic [DATA_W-1:0] wdata_r, wdata_nxt;
   logic [DATA_W-1:0] rdata_r, rdata_nxt;
   logic done_r, done_nxt;
   logic rewrite_r, rewrite_nxt;
   logic ack_r, ack_nxt;
   logic [31:0] dat_r, dat_nxt;
   logic [1:0] wait_r, wait_nxt;
   logic bus_hit;
   logic go;

   assign bus_hit = cyc_i && stb_i && !ack_r;
   assign go = bus_hit && we_i && adr_i == dpram_pkg::REG_CTRL &&
      sel_i[0] && dat_i[dpram_pkg::CTRL_GO];

   always_comb begin
      state_nxt = state_r;
      ctrl_nxt = ctrl_r;
      addr_nxt = addr_r;
      wdata_nxt = wdata_r;
      rdata_nxt = rdata_r;
      done_nxt = done_r;
      rewrite_nxt = rewrite_r;
      wait_nxt = wait_r;
      ack_nxt = bus_hit;
      dat_nxt = '0;
      if (bus_hit && we_i) begin
         case (adr_i)
            dpram_pkg::REG_CTRL: ctrl_nxt = dat_i;
            dpram_pkg::REG_ADDR: addr_nxt = dat_i[ADDR_W-1:0];
            dpram_pkg::REG_WDATA: wdata_nxt = dat_i[DATA_W-1:0];
            default: ;
         endcase
      end else if (bus_hit) begin
         case (adr_i)
            dpram_pkg::REG_CTRL: dat_nxt = ctrl_r;
            dpram_pkg::REG_ADDR: dat_nxt = 32'(addr_r);
            dpram_pkg::REG_WDATA: dat_nxt = 32'(wdata_r);
            dpram_pkg::REG_RDATA: dat_nxt = 32'(rdata_r);
            dpram_pkg::REG_STATUS: dat_nxt = {29'h0, rewrite_r, done_r,
               state_r != IDLE};
            default: dat_nxt = '0;
         endcase
      end
      case (state_r)
         IDLE: begin
            if (go) begin
               state_nxt = ISSUE;
               done_nxt = 1'b0;
            end
         end
         ISSUE: begin
            if (ctrl_r[dpram_pkg::CTRL_NOP]) begin
               rewrite_nxt = 1'b1;
            end else if (ctrl_r[dpram_pkg::CTRL_WRITE]) begin
               rewrite_nxt = 1'b0;
            end
            if (ctrl_r[dpram_pkg::CTRL_INCR]) begin
               addr_nxt = addr_r + 1'b1;
            end
            // Flow read needs one wait, pipelined two, from the write-to-read delay; no skew margin is added
            wait_nxt = 2'(dpram_pkg::WRITE_TO_READ_CYCLES - 1) +
               {1'b0, ctrl_r[dpram_pkg::CTRL_MODE]};
            state_nxt = (ctrl_r[dpram_pkg::CTRL_WRITE] ||
               ctrl_r[dpram_pkg::CTRL_NOP]) ? IDLE : WAIT;
            done_nxt = state_nxt == IDLE;
         end
         WAIT: begin
            wait_nxt = wait_r - 1'b1;
            if (wait_r == 2'h1) begin
               // Port shares this clock: its data bus is sampled directly
               rdata_nxt = link.data_bus;
               state_nxt = CAPTURE;
            end
         end
         CAPTURE: begin
            done_nxt = 1'b1;
            state_nxt = IDLE;
         end
         default: state_nxt = IDLE;
      endcase
      if (rst_i) begin
         state_nxt = IDLE;
         ctrl_nxt = dpram_pkg::CTRL_RESET;
         addr_nxt = '0;
         wdata_nxt = '0;
         rdata_nxt = '0;
         done_nxt = 1'b0;
         rewrite_nxt = 1'b0;
         wait_nxt = '0;
         ack_nxt = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (ce_i || rst_i) begin
         state_r <= state_nxt;
         ctrl_r <= ctrl_nxt;
         addr_r <= addr_nxt;
         wdata_r <= wdata_nxt;
         rdata_r <= rdata_nxt;
         done_r <= done_nxt;
         rewrite_r <= rewrite_nxt;
         wait_r <= wait_nxt;
         ack_r <= ack_nxt;
         dat_r <= dat_nxt;
      end
   end

   assign ack_o = ack_r;
   assign dat_o = dat_r;
   // Only ISSUE is an active cycle; bank bit set holds select_high_active inactive
   assign link.select_low_active_n = !(state_r == ISSUE &&
      !ctrl_r[dpram_pkg::CTRL_NOP]);
   assign link.select_high_active = !ctrl_r[dpram_pkg::CTRL_BANK];
   assign link.write_n = !ctrl_r[dpram_pkg::CTRL_WRITE];
   assign link.address_strobe_load_n = 1'b0;
   assign link.count_advance_enable_n = 1'b1;
   assign link.counter_clear_n = !(state_r == ISSUE &&
      ctrl_r[dpram_pkg::CTRL_CLEAR]);
   assign link.upper_byte_select_n = !ctrl_r[dpram_pkg::CTRL_UPPER];
   assign link.lower_byte_select_n = !ctrl_r[dpram_pkg::CTRL_LOWER];
   assign link.output_enable_n = ctrl_r[dpram_pkg::CTRL_WRITE];
   assign link.addr = addr_r;
   assign link.ctl_data = wdata_r;
   assign link.ctl_data_oe = state_r == ISSUE &&
      ctrl_r[dpram_pkg::CTRL_WRITE];
endmodule

// file: verif/dpram_chk.sv
// Concurrent checks on the link between one controller and its port
`timescale 1ns/100ps
module dpram_chk (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic pipelined_i,
   input wire logic select_low_active_n,
   input wire logic select_high_active,
   input wire logic write_n,
   input wire logic address_strobe_load_n,
   input wire logic output_enable_n,
   input wire logic ctl_data_oe,
   input wire logic mem_data_oe
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic sel;
   logic off;
   assign sel = !select_low_active_n && select_high_active;
   assign off = !sel;
   a_oe_gate: assert property (output_enable_n |-> !mem_data_oe)
      else $error("port drives data while output enable is off");
   a_desel_float: assert property (!pipelined_i && off |=> !mem_data_oe)
      else $error("flow port still drives after deselect edge");
   a_desel_idle: assert property (off ##1 off |=> !mem_data_oe)
      else $error("deselected port drives data");
   a_flow_drive: assert property (!pipelined_i && sel && write_n
      ##1 !output_enable_n |-> mem_data_oe)
      else $error("flow read data missing after one edge");
   a_write_quiet: assert property (!pipelined_i && sel && !write_n
      |=> !mem_data_oe)
      else $error("port drives data after a write edge");
   a_pipe_drive: assert property (pipelined_i && sel && write_n
      ##1 !output_enable_n [*2] |-> mem_data_oe)
      else $error("pipelined read data missing after two edges");
   a_pipe_late: assert property (pipelined_i && off
      ##1 sel && write_n |=> !mem_data_oe)
      else $error("pipelined read data came one edge early");
   a_strobe_load: assert property (sel |-> !address_strobe_load_n)
      else $error("access without address load");
   a_no_contend: assert property (!(ctl_data_oe && mem_data_oe))
      else $error("both ends drive the data bus");
   c_write: cover property (sel && !write_n);
   c_flow_read: cover property (!pipelined_i && sel && write_n);
   c_pipe_read: cover property (pipelined_i && sel && write_n);
endmodule

// file: verif/tb_top.sv
// Bench: two controllers on the two ports of one memory, model checked
`timescale 1ns/100ps
`define CHK(nm, ex, got) \
   checked++; \
   if ((got) !== (ex)) begin \
      n_fail++; \
      $display("Error %s expected %h seen %h", nm, ex, got); \
   end
module tb_top;
   logic clk_i = 1'h0;
   logic rst_i = 1'h1;
   logic pipe [2] = '{1'h0, 1'h0};
   logic cyc [2] = '{1'h0, 1'h0};
   logic we [2] = '{1'h0, 1'h0};
   logic [7:0] adr [2] = '{8'h00, 8'h00};
   logic [31:0] dat [2] = '{32'h0, 32'h0};
   logic [31:0] dat_o [2];
   logic ack [2];
   logic wo [2];
   logic [15:0] ao [2];
   logic [15:0] dwo [2];
   logic [1:0] lo [2];
   logic [15:0] shadow [16];
   logic [31:0] stat;
   logic [31:0] lfsr = 32'hFAE8;
   int n_fail = 0;
   int checked = 0;
   for (genvar g = 0; g < 2; g++) begin : side
      dpram_if link ();
      dpram_port u_dpram_port (.clk_i(clk_i), .other_clk_i(clk_i),
         .rst_i(rst_i), .ce_i(1'h1), .pipelined_i(pipe[g]), .link(link),
         .other_we_i(wo[1-g]), .other_addr_i(ao[1-g]),
         .other_wdata_i(dwo[1-g]), .other_lanes_i(lo[1-g]),
         .we_o(wo[g]), .addr_o(ao[g]), .wdata_o(dwo[g]), .lanes_o(lo[g]));
      dpram_ctrl u_dpram_ctrl (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'h1),
         .cyc_i(cyc[g]), .stb_i(cyc[g]), .we_i(we[g]), .adr_i(adr[g]),
         .sel_i(4'hF), .dat_i(dat[g]), .dat_o(dat_o[g]), .ack_o(ack[g]),
         .link(link));
   end
   dpram_chk u_dpram_chk (.clk_i(clk_i), .rst_i(rst_i),
      .pipelined_i(pipe[0]),
      .select_low_active_n(side[0].link.select_low_active_n),
      .select_high_active(side[0].link.select_high_active),
      .write_n(side[0].link.write_n),
      .address_strobe_load_n(side[0].link.address_strobe_load_n),
      .output_enable_n(side[0].link.output_enable_n),
      .ctl_data_oe(side[0].link.ctl_data_oe),
      .mem_data_oe(side[0].link.mem_data_oe));
   initial begin
      forever #10 clk_i = ~clk_i;
   end
   function automatic logic [31:0] next_rand(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   function automatic logic [15:0] merge(input logic [15:0] o,
         input logic [15:0] n, input logic [1:0] ln);
      return {ln[1] ? n[15:8] : o[15:8], ln[0] ? n[7:0] : o[7:0]};
   endfunction
   // Write command with upper lane on ln[1], lower lane on ln[0]
   function automatic logic [8:0] wctl(input logic [1:0] ln);
      return {5'h00, ln[0], ln[1], 2'h2};
   endfunction
   task tally_and_finish();
      if (n_fail == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task wb(input int s, input logic w, input logic [7:0] a,
         input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc[s] <= 1'h1;
      we[s] <= w;
      adr[s] <= a;
      dat[s] <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack[s] !== 1'h1 && n < 40);
      q = dat_o[s];
      cyc[s] <= 1'h0;
      if (n >= 40) begin
         n_fail++;
         tally_and_finish();
      end
   endtask
   // Load address and data, start, wait for completion, fetch read data
   task op(input int s, input logic [8:0] c, input logic [15:0] a,
         input logic [15:0] d, output logic [15:0] q);
      logic [31:0] r;
      int n;
      n = 0;
      wb(s, 1'h1, dpram_pkg::REG_ADDR, {16'h0000, a}, r);
      wb(s, 1'h1, dpram_pkg::REG_WDATA, {16'h0000, d}, r);
      wb(s, 1'h1, dpram_pkg::REG_CTRL,
         {23'h0, c} | 32'h1 | {27'h0, pipe[s], 4'h0}, r);
      do begin
         wb(s, 1'h0, dpram_pkg::REG_STATUS, 32'h0, r);
         n++;
      end while ((r[dpram_pkg::STAT_BUSY] !== 1'h0
         || r[dpram_pkg::STAT_DONE] !== 1'h1) && n < 20);
      stat = r;
      wb(s, 1'h0, dpram_pkg::REG_RDATA, 32'h0, r);
      q = r[15:0];
      if (n >= 20) begin
         n_fail++;
         tally_and_finish();
      end
   endtask
   initial begin
      logic [15:0] q;
      logic [15:0] d;
      logic [15:0] a;
      logic [31:0] r;
      logic [1:0] ln;
      int s;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'h0;
      for (int i = 0; i < 16; i++) begin
         lfsr = next_rand(lfsr);
         shadow[i] = lfsr[15:0];
         op(i % 2, wctl(2'h3), 16'(i), shadow[i], q);
      end
      for (int i = 0; i < 40; i++) begin
         lfsr = next_rand(lfsr);
         s = lfsr[16];
         pipe[0] <= lfsr[17];
         pipe[1] <= lfsr[18];
         a = {12'h000, lfsr[23:20]};
         ln = lfsr[25:24] == 2'h0 ? 2'h3 : lfsr[25:24];
         d = lfsr[15:0];
         op(s, wctl(ln), a, d, q);
         shadow[a] = merge(shadow[a], d, ln);
         op(1 - s, 9'h00C, a, 16'h0000, q);
         `CHK("cross read", shadow[a], q)
         op(s, 9'h00C, a, 16'h0000, q);
         `CHK("lane read", shadow[a], q)
      end
      for (int m = 0; m < 2; m++) begin
         pipe[0] <= m[0];
         pipe[1] <= m[0];
         d = 16'hA5C3 ^ 16'(m);
         op(m, wctl(2'h3) | 9'h040, 16'h0009, d, q);
         shadow[0] = d;
         op(1 - m, 9'h00C, 16'h0000, 16'h0000, q);
         `CHK("clear write", d, q)
         op(m, 9'h04C, 16'h0005, 16'h0000, q);
         `CHK("clear read", shadow[0], q)
         op(m, 9'h00C, 16'h0009, 16'h0000, q);
         `CHK("clear kept", shadow[9], q)
         op(m, wctl(2'h3) | 9'h080, 16'h0003, ~shadow[3], q);
         op(m, 9'h08C, 16'h0003, 16'h0000, q);
         `CHK("deselect read", 16'h0000, q)
         op(m, 9'h00C, 16'h0003, 16'h0000, q);
         `CHK("deselect write", shadow[3], q)
         op(m, 9'h100, 16'h0004, 16'h0000, q);
         `CHK("rewrite flag", 1'h1, stat[dpram_pkg::STAT_REWRITE])
         op(m, wctl(2'h3), 16'h0004, shadow[4], q);
         `CHK("rewrite clear", 1'h0, stat[dpram_pkg::STAT_REWRITE])
         op(m, 9'h00C, 16'h0004, 16'h0000, q);
         `CHK("rewritten", shadow[4], q)
      end
      wb(0, 1'h0, 8'h20, 32'h0, r);
      `CHK("unmapped", 32'h0, r)
      tally_and_finish();
   end
endmodule
